// file: hw/hbgd_ctrl.sv
// half-bridge gate drive control for seven channels
//
// Behaviour
// - reset enters reduced power, driver enable 0, pump off, gate currents off.
// - diagnostic test currents stay enabled in reduced power.
// - driver enable at 1 moves to full power while sleep is low.
// - pull-downs active at power-up, reduced power and sleep; gates off.
// - each channel configured alone; continuous on and pwm modes.
// - channel enable 0 forces both gates off; 1 enables; rewrite restarts.
// - channel seven split select: 0 half-bridge, 1 split arrangement.
// - split select ignored for channels one to six.
// - polarity 0 drives low side, 1 drives high side.
// - pwm enable 0 holds continuous on; 1 follows selected pwm input.
// - pwm enable change applies after chip select rising edge.
// - two-bit source field picks pwm input one to four.
// - source routing change applies after chip select rising edge.
// - pwm low turns chosen driver off, complementary on.
// - pwm high turns chosen driver on, complementary off; active high.
// - split with pwm off turns both drivers of channel seven on.
// - split with pwm on: polarity side stays on, other follows pwm.
// - any number of channels may share one pwm input.
`timescale 1ns/1ps
`default_nettype none
module hbgd_ctrl
    import hbgd_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // serial port settings and strobe, sleep input
    input wire hbgd_pkg::hbgd_cfg_t i_cfg,
    input wire logic i_serial_chip_select_n,
    input wire logic i_sleep,
    // external pwm inputs
    input wire logic [hbgd_pkg::HBGD_PWM_INPUTS-1:0] i_pwm_input,
    // gate drive and power outputs
    output logic [hbgd_pkg::HBGD_CHANNELS-1:0] o_high_gate_out,
    output logic [hbgd_pkg::HBGD_CHANNELS-1:0] o_low_gate_out,
    output logic [hbgd_pkg::HBGD_CHANNELS-1:0] o_gate_pulldown,
    output logic o_charge_pump_on,
    output logic o_gate_current_on,
    output logic o_diag_current_on,
    output logic o_full_power
);
    import hbgd_pkg::*;

    logic cs_q;
    logic cs_rise;
    hbgd_cfg_t cfg_q;
    logic [HBGD_PWM_INPUTS-1:0] pwm_meta_q;
    logic [HBGD_PWM_INPUTS-1:0] pwm_sync_q;
    hbgd_pwr_t pwr_q;
    hbgd_gate_t gate_d;

    // picks the pwm input named by a two-bit source field
    function automatic logic pick_pwm(
        input logic [HBGD_PWM_INPUTS-1:0] pwm,
        input logic [HBGD_SRC_W-1:0] sel
    );
        pick_pwm = pwm[sel];
    endfunction

    // chip select edge detect
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cs_q <= 1'b1;
        end else begin
            cs_q <= i_serial_chip_select_n;
        end
    end
    assign cs_rise = i_serial_chip_select_n & ~cs_q;

    // settings latched at the end of a write
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_q.driver_power_enable <= HBGD_DRIVER_POWER_ENABLE_RST;
            cfg_q.ch7_split_select <= HBGD_SPLIT_RST;
            cfg_q.channel_output_enable <= HBGD_EN_RST;
            cfg_q.channel_polarity <= HBGD_POL_RST;
            cfg_q.channel_pwm_enable <= HBGD_PWM_EN_RST;
            cfg_q.pwm_source_select <= HBGD_SRC_RST;
        end else if (cs_rise) begin
            cfg_q <= i_cfg;
        end
    end

    // two-flop pwm synchroniser
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwm_meta_q <= '0;
            pwm_sync_q <= '0;
        end else begin
            pwm_meta_q <= i_pwm_input;
            pwm_sync_q <= pwm_meta_q;
        end
    end

    // power state machine
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pwr_q <= HBGD_REDUCED;
        end else begin
            case (pwr_q)
                HBGD_REDUCED: begin
                    if (cfg_q.driver_power_enable && !i_sleep) begin
                        pwr_q <= HBGD_FULL;
                    end
                end
                HBGD_FULL: begin
                    if (!cfg_q.driver_power_enable || i_sleep) begin
                        pwr_q <= HBGD_REDUCED;
                    end
                end
                default: pwr_q <= HBGD_REDUCED;
            endcase
        end
    end

    // per-channel gate decision
    always_comb begin
        logic pwm;
        logic pol;
        logic live;
        gate_d = '0;
        pwm = 1'b0;
        pol = 1'b0;
        live = 1'b0;
        for (int ch = 0; ch < HBGD_CHANNELS; ch++) begin
            pwm = pick_pwm(pwm_sync_q,
                cfg_q.pwm_source_select[ch*HBGD_SRC_W +: HBGD_SRC_W]);
            pol = cfg_q.channel_polarity[ch];
            live = (pwr_q == HBGD_FULL) && !i_sleep
                && cfg_q.channel_output_enable[ch];
            if (!live) begin
                gate_d.gate_pulldown[ch] = 1'b1;
            end else if (ch == HBGD_SPLIT_CH && cfg_q.ch7_split_select) begin
                // split arrangement, channel seven only
                if (!cfg_q.channel_pwm_enable[ch]) begin
                    gate_d.high_gate_out[ch] = 1'b1;
                    gate_d.low_gate_out[ch] = 1'b1;
                end else if (!pol) begin
                    gate_d.low_gate_out[ch] = 1'b1;
                    gate_d.high_gate_out[ch] = pwm;
                end else begin
                    gate_d.high_gate_out[ch] = 1'b1;
                    gate_d.low_gate_out[ch] = pwm;
                end
            end else if (!cfg_q.channel_pwm_enable[ch]) begin
                // continuous on, half-bridge
                gate_d.high_gate_out[ch] = pol;
                gate_d.low_gate_out[ch] = ~pol;
            end else begin
                // pwm mode: high turns on polarity side, low the other
                gate_d.high_gate_out[ch] = pol ? pwm : ~pwm;
                gate_d.low_gate_out[ch] = pol ? ~pwm : pwm;
            end
        end
    end

    // registered gate outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_high_gate_out <= '0;
            o_low_gate_out <= '0;
            o_gate_pulldown <= '1;
        end else begin
            o_high_gate_out <= gate_d.high_gate_out;
            o_low_gate_out <= gate_d.low_gate_out;
            o_gate_pulldown <= gate_d.gate_pulldown;
        end
    end

    // registered power outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_charge_pump_on <= 1'b0;
            o_gate_current_on <= 1'b0;
            o_diag_current_on <= 1'b1;
            o_full_power <= 1'b0;
        end else begin
            o_charge_pump_on <= (pwr_q == HBGD_FULL);
            o_gate_current_on <= (pwr_q == HBGD_FULL);
            o_diag_current_on <= 1'b1;
            o_full_power <= (pwr_q == HBGD_FULL);
        end
    end
endmodule
`default_nettype wire

// file: hw/hbgd_pkg.sv
// package of constants and types for the half-bridge gate drive control
package hbgd_pkg;
    localparam int HBGD_CHANNELS = 7;
    localparam int HBGD_PWM_INPUTS = 4;
    localparam int HBGD_SRC_W = 2;
    localparam int HBGD_SPLIT_CH = 6;
    localparam logic HBGD_DRIVER_POWER_ENABLE_RST = 1'h0;
    localparam logic [6:0] HBGD_EN_RST = 7'h00;
    localparam logic [6:0] HBGD_POL_RST = 7'h00;
    localparam logic [6:0] HBGD_PWM_EN_RST = 7'h00;
    localparam logic [13:0] HBGD_SRC_RST = 14'h0000;
    localparam logic HBGD_SPLIT_RST = 1'h0;
    localparam logic [1:0] HBGD_SYNC_RST = 2'h0;

    // control settings as written by the serial port
    typedef struct packed {
        logic driver_power_enable;
        logic ch7_split_select;
        logic [6:0] channel_output_enable;
        logic [6:0] channel_polarity;
        logic [6:0] channel_pwm_enable;
        logic [13:0] pwm_source_select;
    } hbgd_cfg_t;

    // gate drive state of all channels
    typedef struct packed {
        logic [6:0] high_gate_out;
        logic [6:0] low_gate_out;
        logic [6:0] gate_pulldown;
    } hbgd_gate_t;

    // power state
    typedef enum logic [0:0] {
        HBGD_REDUCED = 1'b0,
        HBGD_FULL = 1'b1
    } hbgd_pwr_t;
endpackage

// file: sim/hbgd_ctrl_bench.sv
// self-checking bench for the gate drive control
`timescale 1ns/1ps
`default_nettype none
module hbgd_ctrl_bench;
    import hbgd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    hbgd_cfg_t cfg, cur;
    logic cs_n, pump, cur_on, diag, full;
    logic [3:0] pwm;
    logic [6:0] hi, lo, pd;
    logic [63:0] r;
    integer seed = 85259;
    integer errors = 0;
    integer n_checks = 0;
    integer cyc = 0;
    wire logic [24:0] outs = {hi, lo, pd, pump, cur_on, diag, full};
    hbgd_ctrl dut_u (.i_clk(clk), .i_rst(rst), .i_cfg(cfg),
        .i_serial_chip_select_n(cs_n), .i_sleep(sleep), .i_pwm_input(pwm),
        .o_high_gate_out(hi), .o_low_gate_out(lo), .o_gate_pulldown(pd),
        .o_charge_pump_on(pump), .o_gate_current_on(cur_on),
        .o_diag_current_on(diag), .o_full_power(full));
    hbgd_host host_u (.i_clk(clk), .o_cfg(cfg), .o_serial_chip_select_n(cs_n),
        .o_pwm_input(pwm));
    initial begin
        forever #5 clk = ~clk;
    end
    // expected outputs from settings, pwm and sleep
    function automatic logic [24:0] model(input hbgd_cfg_t c,
        input logic [3:0] p, input logic s);
        logic [6:0] h, l;
        logic f, on;
        f = c.driver_power_enable && !s;
        for (int i = 0; i < 7; i++) begin
            on = c.channel_pwm_enable[i] ? p[c.pwm_source_select[2*i+:2]] : 1'b1;
            h[i] = c.channel_polarity[i] ? on : !on;
            l[i] = !h[i];
            if (i == 6 && c.ch7_split_select) begin
                h[i] = !c.channel_pwm_enable[i] || c.channel_polarity[i] || on;
                l[i] = !c.channel_pwm_enable[i] || !c.channel_polarity[i] || on;
            end
            if (!f || !c.channel_output_enable[i]) begin
                h[i] = 1'b0;
                l[i] = 1'b0;
            end
        end
        return {h, l, ~(h | l), f, f, 1'b1, f};
    endfunction
    task check(input logic [24:0] seen, input logic [24:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t outputs %h expected %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end
    initial begin
        cur = '0;
        repeat (16) @(negedge clk);
        check(outs, model(cur, pwm, sleep));
        rst = 1'b0;
        for (int k = 0; k < 60; k++) begin
            r = {$random(seed), $random(seed)};
            cur = r[36:0];
            cur.driver_power_enable = (k % 8 != 0);
            host_u.write(cur);
            host_u.drive_pwm(r[40:37]);
            repeat (4) @(negedge clk);
            check(outs, model(cur, pwm, sleep));
        end
        cur = {1'b1, 1'b0, 7'h7F, 7'h7F, 7'h7F, 14'h0000};
        host_u.write(cur);
        host_u.drive_pwm(4'h0);
        repeat (4) @(negedge clk);
        host_u.drive_pwm(4'h1);
        @(negedge clk);
        check(outs, model(cur, 4'h0, sleep));
        repeat (3) @(negedge clk);
        check(outs, model(cur, pwm, sleep));
        sleep = 1'b1;
        repeat (5) @(negedge clk);
        check(outs, model(cur, pwm, sleep));
        sleep = 1'b0;
        repeat (5) @(negedge clk);
        check(outs, model(cur, pwm, sleep));
        rst = 1'b1;
        @(negedge clk);
        check(outs, model('0, pwm, sleep));
        rst = 1'b0;
        repeat (3) @(negedge clk);
        check(outs, model('0, pwm, sleep));
        end_of_test();
    end
endmodule
`default_nettype wire

// file: sim/hbgd_host.sv
// host model: serial settings write and pwm inputs
`timescale 1ns/1ps
`default_nettype none
module hbgd_host (
    // clock
    input wire logic i_clk,
    // toward the device
    output var hbgd_pkg::hbgd_cfg_t o_cfg,
    output var logic o_serial_chip_select_n,
    output var logic [3:0] o_pwm_input
);
    import hbgd_pkg::*;
    // idle levels at time zero
    initial begin
        o_cfg = '0;
        o_serial_chip_select_n = 1'b1;
        o_pwm_input = 4'h0;
    end
    // one write, split wiring assumed fitted
    task write(input hbgd_cfg_t v);
        @(negedge i_clk);
        o_cfg = v;
        o_serial_chip_select_n = 1'b0;
        @(negedge i_clk);
        o_serial_chip_select_n = 1'b1;
        @(negedge i_clk);
        o_cfg = ~v; // released bus shows stale inverse
    endtask
    // pwm edges staggered, one input per cycle
    task drive_pwm(input logic [3:0] v);
        for (int i = 0; i < 4; i++) begin
            if (o_pwm_input[i] !== v[i]) begin
                @(negedge i_clk);
                o_pwm_input[i] = v[i];
            end
        end
    endtask
endmodule
`default_nettype wire

// file: sim/hbgd_monitor.sv
// port assertions for the gate drive control
`timescale 1ns/1ps
`default_nettype none
module hbgd_monitor (
    // clock, reset and inputs
    input wire logic i_clk,
    input wire logic i_rst,
    input wire hbgd_pkg::hbgd_cfg_t i_cfg,
    input wire logic i_serial_chip_select_n,
    input wire logic i_sleep,
    input wire logic [3:0] i_pwm_input,
    // outputs of the block
    input wire logic [6:0] o_high_gate_out,
    input wire logic [6:0] o_low_gate_out,
    input wire logic [6:0] o_gate_pulldown,
    input wire logic o_charge_pump_on,
    input wire logic o_gate_current_on,
    input wire logic o_diag_current_on,
    input wire logic o_full_power
);
    import hbgd_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // channels with any gate driven
    wire logic [6:0] on_w = o_high_gate_out | o_low_gate_out;
    logic up_w;
    assign up_w = i_cfg.driver_power_enable && !i_sleep;
    chk_diag_always: assert property (o_diag_current_on)
        else $error("diag current off");
    chk_pump_power: assert property (o_charge_pump_on == o_full_power)
        else $error("pump differs from power state");
    chk_current_power: assert property (o_gate_current_on == o_full_power)
        else $error("gate current differs from power state");
    chk_reduced_gates_off: assert property (!o_full_power && $past(!o_full_power)
        |-> on_w == 7'h00) else $error("gate on in reduced power");
    chk_pulldown_off: assert property ((o_gate_pulldown & on_w) == 7'h00)
        else $error("pulldown with gate on");
    chk_bridge_excl: assert property ((o_high_gate_out & o_low_gate_out & 7'h3F)
        == 7'h00) else $error("both gates on in bridge");
    chk_sleep_down: assert property (i_sleep [*4] |-> !o_full_power)
        else $error("full power while asleep");
    chk_write_down: assert property ($rose(i_serial_chip_select_n) &&
        !i_cfg.driver_power_enable |-> ##3 !o_full_power)
        else $error("no return to reduced power");
    chk_write_up: assert property ($rose(i_serial_chip_select_n) && up_w
        ##1 !i_sleep [*3] |-> o_full_power) else $error("no full power");
    cover property ($rose(o_full_power));
    cover property (o_high_gate_out[6] && o_low_gate_out[6]);
    cover property ($fell(o_full_power));
endmodule
bind hbgd_ctrl hbgd_monitor mon_u (.i_clk, .i_rst, .i_cfg,
    .i_serial_chip_select_n, .i_sleep, .i_pwm_input, .o_high_gate_out,
    .o_low_gate_out, .o_gate_pulldown, .o_charge_pump_on, .o_gate_current_on,
    .o_diag_current_on, .o_full_power);
`default_nettype wire
